// file: bench/tb.sv
// Self-checking bench for the center-aligned timer
`timescale 1ns/1ps
module tb;
    localparam CH_N = 2;
    localparam [15:0] MOD = 16'h0004;
    logic        core_clk_i, rstn_i, count_tick_i, center_align_select_i;
    logic        background_debug_halt_i, counter_wr_i, clr;
    logic        overflow_irq_enable_i, overflow_flag_clr_i;
    logic        modulus_wr_hi_i, modulus_wr_lo_i;
    logic [1:0]  clock_source_select_i, channel_irq_enable_i;
    logic [1:0]  channel_event_flag_clr_i;
    logic [1:0]  channel_value_wr_hi_i, channel_value_wr_lo_i;
    logic [7:0]  wr_data_i;
    logic [3:0]  edge_level_select_i, channel_mode_select_i;
    wire  [15:0] counter_value_o;
    wire  [1:0]  channel_event_flag_o, channel_irq_o;
    wire  [1:0]  channel_out_o, channel_out_en_o;
    wire         counting_down_o, overflow_flag_o, overflow_irq_o;
    int          num_errors, comparisons, high_cnt;
    logic [1:0]  t_els [9] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h2, 2'h2, 2'h3,
                               2'h2, 2'h1};
    logic [15:0] t_val [9] = '{16'h0001, 16'h0001, 16'h0003, 16'h0001,
                               16'h0000, 16'h8002, 16'h8001, 16'h0004,
                               16'h0005};
    int          t_hi  [9] = '{2, 6, 2, 0, 0, 0, 8, 8, 0};
    logic        t_flg [9] = '{1, 1, 1, 1, 0, 0, 0, 0, 0};

    tcp_timer #(.CH_N(CH_N)) i_dut (
        .core_clk_i, .rstn_i, .count_tick_i, .clock_source_select_i,
        .center_align_select_i, .background_debug_halt_i, .counter_wr_i,
        .modulus_wr_hi_i, .modulus_wr_lo_i, .wr_data_i,
        .overflow_irq_enable_i, .overflow_flag_clr_i, .edge_level_select_i,
        .channel_mode_select_i, .channel_irq_enable_i,
        .channel_event_flag_clr_i, .channel_value_wr_hi_i,
        .channel_value_wr_lo_i, .counter_value_o, .counting_down_o,
        .overflow_flag_o, .overflow_irq_o, .channel_event_flag_o,
        .channel_irq_o, .channel_out_o, .channel_out_en_o);
    tcp_load_model i_load (.core_clk_i, .drive_i(channel_out_en_o[0]),
        .level_i(channel_out_o[0]), .clr_i(clr), .high_cnt_o(high_cnt));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr16(input bit chan, input logic [15:0] v);
        {channel_value_wr_hi_i[0], modulus_wr_hi_i} = chan ? 2'h2 : 2'h1;
        wr_data_i = v[15:8];
        step(1);
        {channel_value_wr_hi_i[0], modulus_wr_hi_i} = 2'h0;
        {channel_value_wr_lo_i[0], modulus_wr_lo_i} = chan ? 2'h2 : 2'h1;
        wr_data_i = v[7:0];
        step(1);
        {channel_value_wr_lo_i[0], modulus_wr_lo_i} = 2'h0;
    endtask

    task automatic clear_all();
        {counter_wr_i, overflow_flag_clr_i} = 2'h3;
        channel_event_flag_clr_i = 2'h3;
        step(1);
        {counter_wr_i, overflow_flag_clr_i} = 2'h0;
        channel_event_flag_clr_i = 2'h0;
    endtask

    // Window of eight ticks is one full period, so duty shows as a count
    task automatic t_pwm(input logic [1:0] els, input logic [15:0] v,
                         input int exp_hi, input logic flg);
        clock_source_select_i = 2'h0;
        wr16(1'b1, v);
        clock_source_select_i = 2'h1;
        edge_level_select_i = {2'h0, els};
        overflow_irq_enable_i = els[1];
        channel_irq_enable_i = {1'b0, ~els[0]};
        clear_all();
        {count_tick_i, clr} = 2'h3;
        step(1);
        clr = 1'b0;
        step(7);
        count_tick_i = 1'b0;
        step(1);
        chk("high cycles", exp_hi, high_cnt);
        chk("pin enable", els != 2'h0, channel_out_en_o[0]);
        chk("channel flag", flg, channel_event_flag_o[0]);
        chk("channel irq", flg & ~els[0], channel_irq_o[0]);
        chk("overflow flag", 16'h0001, overflow_flag_o);
        chk("overflow irq", els[1], overflow_irq_o);
        chk("counter", 16'h0000, counter_value_o);
        $display("pwm test els %b value %h done", els, v);
    endtask

    task automatic t_halt();
        clear_all();
        count_tick_i = 1'b1;
        step(3);
        background_debug_halt_i = 1'b1;
        step(4);
        chk("frozen counter", 16'h0003, counter_value_o);
        counter_wr_i = 1'b1;
        step(1);
        counter_wr_i = 1'b0;
        chk("counter write in halt", 16'h0000, counter_value_o);
        background_debug_halt_i = 1'b0;
        step(2);
        chk("counter after halt", 16'h0002, counter_value_o);
        count_tick_i = 1'b0;
        rstn_i = 1'b0;
        #1;
        chk("counter in reset", 16'h0000, counter_value_o);
        chk("flag in reset", 16'h0000, overflow_flag_o);
        step(1);
        rstn_i = 1'b1;
        clock_source_select_i = 2'h0;
        wr16(1'b0, MOD);
        $display("halt and reset test done");
    endtask

    task automatic t_modload();
        clock_source_select_i = 2'h1;
        clear_all();
        wr16(1'b0, 16'h0002);
        count_tick_i = 1'b1;
        step(4);
        chk("counter at old top", 16'h0004, counter_value_o);
        step(7);
        count_tick_i = 1'b0;
        chk("counter with new top", 16'h0001, counter_value_o);
        $display("modulus load test done");
    endtask

    // Compare mode applies at the next tick, edge PWM only at the wrap
    task automatic t_bufload();
        center_align_select_i = 1'b0;
        for (int m = 1; m < 3; m++) begin
            channel_mode_select_i = {2'h2, 2'(m)};
            clear_all();
            wr16(1'b1, 16'h0003 - 16'(m));
            count_tick_i = 1'b1;
            step(2);
            count_tick_i = 1'b0;
            chk("buffered load flag", 16'h0001, channel_event_flag_o[0]);
        end
        $display("buffered load test done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        {rstn_i, count_tick_i, center_align_select_i, clr} = 4'h0;
        {background_debug_halt_i, counter_wr_i, overflow_flag_clr_i} = 3'h0;
        {overflow_irq_enable_i, modulus_wr_hi_i, modulus_wr_lo_i} = 3'h0;
        {clock_source_select_i, channel_irq_enable_i} = 4'h0;
        {channel_value_wr_hi_i, channel_value_wr_lo_i} = 4'h0;
        {channel_event_flag_clr_i, wr_data_i, edge_level_select_i} = 14'h0;
        channel_mode_select_i = 4'hA;
        step(16);
        rstn_i = 1'b1;
        step(1);
        chk("reset counter", 16'h0000, counter_value_o);
        chk("reset pins", 16'h0000, {channel_out_o, channel_out_en_o});
        wr16(1'b0, MOD);
        center_align_select_i = 1'b1;
        for (int i = 0; i < 9; i++)
            t_pwm(t_els[i], t_val[i], t_hi[i], t_flg[i]);
        t_halt();
        t_modload();
        t_bufload();
        final_report();
    end

    initial begin
        repeat (5000) @(posedge core_clk_i);
        num_errors++;
        final_report();
    end
endmodule

bind tcp_timer tcp_timer_monitor #(.CH_N(CH_N)) i_mon (
    .core_clk_i, .rstn_i, .count_tick_i, .clock_source_select_i,
    .center_align_select_i, .background_debug_halt_i, .counter_wr_i,
    .overflow_irq_enable_i, .edge_level_select_i, .counter_value_o,
    .counting_down_o, .overflow_flag_o, .overflow_irq_o,
    .channel_event_flag_o, .channel_irq_o, .channel_out_o,
    .channel_out_en_o);

// file: bench/tcp_load_model.sv
// External load on one channel pin: counts the cycles the pin is high
`timescale 1ns/1ps
module tcp_load_model (
    // Clock
    input  wire core_clk_i,
    // Pin from the timer, count clear from the bench
    input  wire drive_i,
    input  wire level_i,
    input  wire clr_i,
    // Observed high cycles
    output int  high_cnt_o
);
    // An undriven pin settles low through the load's pull-down
    wire pin = drive_i ? level_i : 1'b0;
    always @(posedge core_clk_i)
        high_cnt_o <= clr_i ? 0 : high_cnt_o + int'(pin);
endmodule

// file: bench/tcp_timer_monitor.sv
// Concurrent checks on the timer's ports
`timescale 1ns/1ps
module tcp_timer_monitor #(
    parameter CH_N = 2
) (
    input wire              core_clk_i,
    input wire              rstn_i,
    input wire              count_tick_i,
    input wire [1:0]        clock_source_select_i,
    input wire              center_align_select_i,
    input wire              background_debug_halt_i,
    input wire              counter_wr_i,
    input wire              overflow_irq_enable_i,
    input wire [2*CH_N-1:0] edge_level_select_i,
    input wire [15:0]       counter_value_o,
    input wire              counting_down_o,
    input wire              overflow_flag_o,
    input wire              overflow_irq_o,
    input wire [CH_N-1:0]   channel_event_flag_o,
    input wire [CH_N-1:0]   channel_irq_o,
    input wire [CH_N-1:0]   channel_out_o,
    input wire [CH_N-1:0]   channel_out_en_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    wire tk;
    assign tk = count_tick_i && clock_source_select_i != 2'h0
                && !background_debug_halt_i && !counter_wr_i;

    AST_STEP: assert property (
        tk && center_align_select_i |=>
        counter_value_o == $past(counter_value_o) + 16'h0001 ||
        counter_value_o == $past(counter_value_o) - 16'h0001)
        else $error("counter did not step by one");
    AST_TURN: assert property (
        tk && center_align_select_i && counter_value_o == 16'h0000 |=>
        counter_value_o == 16'h0001 && !counting_down_o)
        else $error("counter did not turn up at zero");
    AST_STOP: assert property (
        clock_source_select_i == 2'h0 && !counter_wr_i |=>
        $stable(counter_value_o))
        else $error("counter moved with clock off");
    AST_HALT: assert property (
        background_debug_halt_i && !counter_wr_i |=>
        $stable(counter_value_o) && $stable(channel_out_o))
        else $error("halt did not freeze");
    AST_CNT_WR: assert property (
        counter_wr_i |=> counter_value_o == 16'h0000 && !counting_down_o)
        else $error("counter write did not zero counter");
    AST_TOP: assert property (
        center_align_select_i && $rose(counting_down_o) |-> overflow_flag_o)
        else $error("no overflow flag at top step");
    AST_OVF_IRQ: assert property (
        overflow_irq_o == (overflow_flag_o && $past(overflow_irq_enable_i)))
        else $error("overflow request wrong");
    AST_CH_IRQ: assert property (
        (channel_irq_o & ~channel_event_flag_o) == '0)
        else $error("channel request without flag");
    AST_OUT_EN: assert property (
        $past(center_align_select_i) && $past(edge_level_select_i[1:0]) == 2'h0
        |-> !channel_out_en_o[0])
        else $error("pin driven with edge level off");
endmodule

// file: core/tcp_timer.v
// Timer counter with center-aligned PWM channels and buffered loads
//
// Function
// - Center mode: count up to modulus, down to zero
// - Pulse twice channel value, period twice modulus
// - Flag on match counting down and up
// - Edge-level 0:0 flags only, output undriven
// - Edge-level 1:0: high down, low up
// - Edge-level X:1: low down, high up
// - Zero or negative value: 0% duty, no flag
// - Value at or above modulus: 100%, no flag
// - Clock off: load on second byte written
// - Modulus applied at wrap or top step
// - Compare value applied at next counter change
// - Edge PWM value applied at counter wrap
// - Center value applied at top step
// - Debug halt freezes counter and outputs
// - Counter write works even in halt
// - Overflow interrupt is enable and flag
// - Channel interrupt is enable and flag
// - Every reset returns block to reset state
// - Overflow flag on top to top-minus-one step
// - Counter write zeroes counter, restores outputs except in compare mode
`timescale 1ns/1ps
`include "tcp_timer_regs.vh"

module tcp_timer #(
    parameter CH_N = 2
) (
    // Clock and reset
    input  wire              core_clk_i,
    input  wire              rstn_i,
    // Counter control
    input  wire              count_tick_i,
    input  wire [1:0]        clock_source_select_i,
    input  wire              center_align_select_i,
    input  wire              background_debug_halt_i,
    input  wire              counter_wr_i,
    // Modulus byte writes
    input  wire              modulus_wr_hi_i,
    input  wire              modulus_wr_lo_i,
    input  wire [7:0]        wr_data_i,
    // Overflow flag and interrupt
    input  wire              overflow_irq_enable_i,
    input  wire              overflow_flag_clr_i,
    // Channel configuration and writes
    input  wire [2*CH_N-1:0] edge_level_select_i,
    input  wire [2*CH_N-1:0] channel_mode_select_i,
    input  wire [CH_N-1:0]   channel_irq_enable_i,
    input  wire [CH_N-1:0]   channel_event_flag_clr_i,
    input  wire [CH_N-1:0]   channel_value_wr_hi_i,
    input  wire [CH_N-1:0]   channel_value_wr_lo_i,
    // Counter state
    output wire [15:0]       counter_value_o,
    output wire              counting_down_o,
    // Overflow status
    output wire              overflow_flag_o,
    output wire              overflow_irq_o,
    // Channel status and pins
    output wire [CH_N-1:0]   channel_event_flag_o,
    output wire [CH_N-1:0]   channel_irq_o,
    output wire [CH_N-1:0]   channel_out_o,
    output wire [CH_N-1:0]   channel_out_en_o
);

    function is_free_running;
        input [15:0] modv;
        begin
            is_free_running = (modv == `TCP_CNT_ZERO) ||
                              (modv == `TCP_CNT_FULL);
        end
    endfunction

    reg  [15:0] cnt_reg;
    reg  [15:0] cnt_next;
    reg         down_reg;
    reg         down_next;
    reg         wrap_evt;
    reg         top_evt;
    reg         tof_reg;
    reg         tof_irq_reg;
    wire [15:0] counter_modulus;
    wire        clocks_off;
    wire        center;
    wire        step;
    wire        tof_next;

    assign clocks_off = (clock_source_select_i == `TCP_CLKS_OFF);
    assign center     = center_align_select_i;
    // Halt suppresses every counter step, so outputs hold too
    assign step = count_tick_i & ~clocks_off & ~background_debug_halt_i;

    // Active modulus
    tcp_wbuf #(
        .RESET_VALUE (`TCP_RST_MOD)
    ) u_mod_buf (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .wr_hi_i     (modulus_wr_hi_i),
        .wr_lo_i     (modulus_wr_lo_i),
        .wr_data_i   (wr_data_i),
        .block_i     (1'b0),
        .immediate_i (clocks_off),
        .apply_i     (center ? top_evt : wrap_evt),
        .active_o    (counter_modulus)
    );

    // Counter next state
    always @* begin
        cnt_next  = cnt_reg;
        down_next = down_reg;
        wrap_evt  = 1'b0;
        top_evt   = 1'b0;
        if (counter_wr_i) begin
            // Allowed during halt; value written is irrelevant
            cnt_next  = `TCP_CNT_ZERO;
            down_next = 1'b0;
        end else if (step && center) begin
            if (!down_reg) begin
                if (cnt_reg == counter_modulus) begin
                    cnt_next  = cnt_reg - `TCP_CNT_ONE;
                    down_next = 1'b1;
                    top_evt   = 1'b1;
                end else begin
                    cnt_next = cnt_reg + `TCP_CNT_ONE;
                end
            end else begin
                if (cnt_reg == `TCP_CNT_ZERO) begin
                    cnt_next  = `TCP_CNT_ONE;
                    down_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg - `TCP_CNT_ONE;
                end
            end
        end else if (step) begin
            down_next = 1'b0;
            if (is_free_running(counter_modulus) ?
                (cnt_reg == `TCP_CNT_FULL) :
                (cnt_reg == counter_modulus)) begin
                cnt_next = `TCP_CNT_ZERO;
                wrap_evt = 1'b1;
            end else begin
                cnt_next = cnt_reg + `TCP_CNT_ONE;
            end
        end
    end

    // Hardware set wins over a clear in the same cycle
    assign tof_next = wrap_evt | top_evt |
                      (tof_reg & ~overflow_flag_clr_i);

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg     <= `TCP_CNT_ZERO;
            down_reg    <= 1'b0;
            tof_reg     <= 1'b0;
            tof_irq_reg <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            down_reg    <= down_next;
            tof_reg     <= tof_next;
            tof_irq_reg <= tof_next & overflow_irq_enable_i;
        end
    end

    assign counter_value_o = cnt_reg;
    assign counting_down_o = down_reg;
    assign overflow_flag_o = tof_reg;
    assign overflow_irq_o  = tof_irq_reg;

    // Channels
    genvar g;
    generate
        for (g = 0; g < CH_N; g = g + 1) begin : g_ch
            wire [1:0]  els;
            wire [1:0]  msel;
            wire [15:0] cv;
            wire        mode_cmp;
            wire        mode_edge;
            wire        mode_cap;
            wire        apply;
            wire        zero_duty;
            wire        full_duty;
            wire        match;
            wire        hit;
            wire        inv;
            wire        flag_next;
            reg         flag_reg;
            reg         irq_reg;
            reg         out_reg;
            reg         drive_reg;

            assign els  = edge_level_select_i[2*g +: 2];
            assign msel = channel_mode_select_i[2*g +: 2];
            assign inv  = els[`TCP_ELS_INV_BIT];
            assign mode_cmp  = ~center & (msel == `TCP_MS_COMPARE);
            assign mode_edge = ~center & msel[`TCP_MS_EDGE_BIT];
            assign mode_cap  = ~center & (msel == `TCP_MS_CAPTURE);
            assign apply = center ? top_evt :
                           mode_cmp ? step :
                           mode_edge & wrap_evt;

            // Active channel compare value
            tcp_wbuf #(
                .RESET_VALUE (`TCP_RST_CV)
            ) u_cv_buf (
                .core_clk_i  (core_clk_i),
                .rstn_i      (rstn_i),
                .wr_hi_i     (channel_value_wr_hi_i[g]),
                .wr_lo_i     (channel_value_wr_lo_i[g]),
                .wr_data_i   (wr_data_i),
                .block_i     (mode_cap),
                .immediate_i (clocks_off),
                .apply_i     (apply),
                .active_o    (cv)
            );

            // Negative values are treated as zero duty
            assign zero_duty = (cv == `TCP_CNT_ZERO) | cv[`TCP_CNT_MSB];
            assign full_duty = ~cv[`TCP_CNT_MSB] & (cv >= counter_modulus)
                               & (counter_modulus != `TCP_CNT_ZERO);
            // Match is taken as the counter arrives at the value
            assign match = step & ~counter_wr_i & (cnt_next == cv);
            assign hit   = match & ~zero_duty & ~full_duty;
            assign flag_next = (center ? hit : (match & ~mode_cap))
                               | (flag_reg & ~channel_event_flag_clr_i[g]);

            always @(posedge core_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    flag_reg  <= 1'b0;
                    irq_reg   <= 1'b0;
                    out_reg   <= `TCP_OUT_INIT;
                    drive_reg <= 1'b0;
                end else begin
                    flag_reg  <= flag_next;
                    irq_reg   <= flag_next & channel_irq_enable_i[g];
                    drive_reg <= center & (els != `TCP_ELS_NONE);
                    if (counter_wr_i && !mode_cmp) begin
                        out_reg <= `TCP_OUT_INIT;
                    end else if (center && els != `TCP_ELS_NONE &&
                                 !background_debug_halt_i) begin
                        if (zero_duty) begin
                            out_reg <= inv;
                        end else if (full_duty) begin
                            out_reg <= ~inv;
                        end else if (hit) begin
                            // Down match opens the pulse, up match closes it
                            out_reg <= down_next ? ~inv : inv;
                        end
                    end
                end
            end

            assign channel_event_flag_o[g] = flag_reg;
            assign channel_irq_o[g]        = irq_reg;
            assign channel_out_o[g]        = out_reg;
            assign channel_out_en_o[g]     = drive_reg;
        end
    endgenerate

endmodule

// file: core/tcp_wbuf.v
// Byte-pair write buffer with deferred load of a 16-bit active value
`timescale 1ns/1ps
`include "tcp_timer_regs.vh"

module tcp_wbuf #(
    parameter [15:0] RESET_VALUE = `TCP_RST_MOD
) (
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        rstn_i,
    // Byte writes
    input  wire        wr_hi_i,
    input  wire        wr_lo_i,
    input  wire [7:0]  wr_data_i,
    input  wire        block_i,
    // Load control
    input  wire        immediate_i,
    input  wire        apply_i,
    // Active value
    output wire [15:0] active_o
);

    reg  [15:0] buf_reg;
    reg         hi_seen_reg;
    reg         lo_seen_reg;
    reg         pend_reg;
    reg  [15:0] pend_val_reg;
    reg  [15:0] active_reg;
    wire        wr_hi;
    wire        wr_lo;
    wire        pair_done;
    wire [15:0] merged;

    // Writes are dropped while the owner refuses them
    assign wr_hi = wr_hi_i & ~block_i;
    assign wr_lo = wr_lo_i & ~block_i;
    assign pair_done = (wr_hi | wr_lo) & (wr_hi | hi_seen_reg)
                       & (wr_lo | lo_seen_reg);
    assign merged = {wr_hi ? wr_data_i : buf_reg[`TCP_BYTE_HI],
                     wr_lo ? wr_data_i : buf_reg[`TCP_BYTE_LO]};
    assign active_o = active_reg;

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_reg     <= RESET_VALUE;
            hi_seen_reg <= 1'b0;
            lo_seen_reg <= 1'b0;
            pend_reg    <= 1'b0;
            pend_val_reg <= RESET_VALUE;
            active_reg  <= RESET_VALUE;
        end else begin
            buf_reg <= merged;
            if (pair_done) begin
                hi_seen_reg <= 1'b0;
                lo_seen_reg <= 1'b0;
            end else begin
                hi_seen_reg <= hi_seen_reg | wr_hi;
                lo_seen_reg <= lo_seen_reg | wr_lo;
            end
            if (pair_done && immediate_i) begin
                active_reg <= merged;
                pend_reg   <= 1'b0;
            end else if (pair_done) begin
                pend_reg     <= 1'b1;
                pend_val_reg <= merged;
            end else if (pend_reg && apply_i) begin
                // Only a fully written pair is ever applied, even if a
                // later single byte has already landed in the buffer
                active_reg <= pend_val_reg;
                pend_reg   <= 1'b0;
            end
        end
    end

endmodule

// file: include/tcp_timer_regs.vh
// Constants for the center-aligned timer PWM block
`ifndef TCP_TIMER_REGS_VH
`define TCP_TIMER_REGS_VH

`define TCP_CNT_W       16
`define TCP_CNT_MSB     15
`define TCP_CNT_ZERO    16'h0000
`define TCP_CNT_ONE     16'h0001
`define TCP_CNT_FULL    16'hFFFF
`define TCP_RST_MOD     16'h0000
`define TCP_RST_CV      16'h0000
`define TCP_BYTE_HI     15:8
`define TCP_BYTE_LO     7:0
`define TCP_CLKS_OFF    2'h0
`define TCP_ELS_NONE    2'h0
`define TCP_ELS_INV_BIT 0
`define TCP_MS_CAPTURE  2'h0
`define TCP_MS_COMPARE  2'h1
`define TCP_MS_EDGE_BIT 1
`define TCP_OUT_INIT    1'b0

`endif
